// ---- shared/pmla_pkg.sv ----
// constants shared by both ends of the power monitor limit/alert link
// Contract
// - defaults: wide range, continuous three-channel conversion
// - configuration selects wide or narrow shunt range
// - configuration resets each power cycle; host rewrites
// - zero calibration gives zero current and power
// - calibration cleared at power-up; host reprograms
// - overcurrent compares shunt result with limit
// - shunt limit uses shunt result units
// - bus limit uses bus result step
// - power limit compares upper sixteen result bits
// - limits reset each power cycle; host rewrites
// - results two's complement; bus never negative
// - alert reports fault or conversion ready
// - large fault alert may come early
// - marginal fault alert within 0.5-1.5 conversions
// - host budgets 1.5 conversions of alert latency
// - separate shunt/bus times, independent averaging; code uses one averaging count for all channels
package pmla_pkg;
  localparam int CLK_MHZ = 25;
  localparam int DATA_W = 16;
  localparam int RDATA_W = 24;
  localparam int ADDR_W = 4;
  localparam int CH_N = 3;
  localparam int TMR_W = 18;
  localparam int ACC_W = 28;
  localparam int CNT_W = 11;
  // conversion times in us, then averaging counts as log2
  localparam int unsigned CONV_US [8] = '{50, 84, 150, 280, 540, 1052, 2074, 4120};
  localparam logic [3:0] AVG_LOG2 [8] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA};
  localparam logic [1:0] CH_SHUNT = 2'h0;
  localparam logic [1:0] CH_BUS = 2'h1;
  localparam logic [1:0] CH_TEMP = 2'h2;
  // device register indices
  localparam logic [3:0] R_CFG = 4'h0;
  localparam logic [3:0] R_ADC_CFG = 4'h1;
  localparam logic [3:0] R_SHUNT_CAL = 4'h2;
  localparam logic [3:0] R_SHUNT = 4'h3;
  localparam logic [3:0] R_BUS = 4'h4;
  localparam logic [3:0] R_TEMP = 4'h5;
  localparam logic [3:0] R_CURRENT = 4'h6;
  localparam logic [3:0] R_POWER = 4'h7;
  localparam logic [3:0] R_DIAG = 4'h8;
  localparam logic [3:0] R_SHUNT_LIM = 4'h9;
  localparam logic [3:0] R_BUS_LIM = 4'hA;
  localparam logic [3:0] R_POWER_LIM = 4'hB;
  // cfg fields
  localparam int F_NARROW = 0;
  localparam int F_AVG_ALERT = 1;
  localparam int F_ALERT_RDY = 2;
  localparam int F_MASK = 3;
  // adc_cfg fields, 3 bits each
  localparam int F_AVG = 0;
  localparam int F_TEMP_CT = 3;
  localparam int F_SHUNT_CT = 6;
  localparam int F_BUS_CT = 9;
  localparam int F_CH_EN = 12;
  // diag flag bits
  localparam int D_SHUNT_OV = 0;
  localparam int D_BUS_OV = 1;
  localparam int D_POWER_OV = 2;
  localparam int D_CNV_RDY = 3;
  localparam int D_N = 4;
  // reset values
  localparam logic [15:0] CFG_RST = 16'h0038;
  localparam logic [15:0] ADC_CFG_RST = 16'h7B68;
  localparam logic [2:0] CT_RST = 3'h5;
  localparam logic [15:0] CAL_RST = 16'h0000;
  localparam logic [15:0] SHUNT_LIM_RST = 16'h7FFF;
  localparam logic [15:0] BUS_LIM_RST = 16'h7FFF;
  localparam logic [15:0] POWER_LIM_RST = 16'hFFFF;
  localparam int CAL_SHIFT = 11;
  localparam int POW_SHIFT = 6;
  localparam int POW_LIM_LSB = 8;
  // host wishbone map, byte addresses
  localparam int WB_ADR_W = 5;
  localparam logic [4:0] A_CMD = 5'h00;
  localparam logic [4:0] A_WDATA = 5'h04;
  localparam logic [4:0] A_RDATA = 5'h08;
  localparam logic [4:0] A_STATUS = 5'h0C;
  localparam logic [4:0] A_IRQ_ST = 5'h10;
  localparam logic [4:0] A_IRQ_CLR = 5'h14;
  localparam logic [4:0] A_IRQ_EN = 5'h18;
  localparam int C_WE = 4;
  localparam int C_GO = 8;
  localparam int S_BUSY = 0;
  localparam int S_ALERT = 1;
  localparam int S_REPROG = 2;
  localparam int I_DONE = 0;
  localparam int I_ALERT = 1;
  localparam int IRQ_N = 2;
endpackage

// ---- shared/pmla_link_if.sv ----
// register link between host controller and monitor device
`timescale 1ns/1ps
interface pmla_link_if;
  logic req;
  logic we;
  logic [pmla_pkg::ADDR_W-1:0] addr;
  logic [pmla_pkg::DATA_W-1:0] wdata;
  logic ack;
  logic [pmla_pkg::RDATA_W-1:0] rdata;
  logic alert;
  modport dev (input req, input we, input addr, input wdata,
               output ack, output rdata, output alert);
  modport host (output req, output we, output addr, output wdata,
                input ack, input rdata, input alert);
endinterface

// ---- design/pmla_avg.sv ----
// sample averager for one converter channel
`timescale 1ns/1ps
module pmla_avg (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // samples in
  input wire logic smp_vld_i,
  input wire logic [pmla_pkg::DATA_W-1:0] smp_i,
  input wire logic [3:0] log2_i,
  // average out
  output logic avg_vld_o,
  output logic [pmla_pkg::DATA_W-1:0] avg_o
);
  import pmla_pkg::*;
  logic signed [ACC_W-1:0] acc_q;
  logic signed [ACC_W-1:0] sum;
  logic [CNT_W-1:0] cnt_q;
  logic done;
  assign sum = acc_q + ACC_W'($signed(smp_i));
  // >= so that shrinking the count mid-run cannot stall
  assign done = ({1'b0, cnt_q} + 12'h001) >= (12'h001 << log2_i);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_q <= '0;
      cnt_q <= '0;
      avg_vld_o <= 1'b0;
      avg_o <= '0;
    end else begin
      avg_vld_o <= smp_vld_i && done;
      if (smp_vld_i && done) begin
        avg_o <= DATA_W'(sum >>> log2_i);
        acc_q <= '0;
        cnt_q <= '0;
      end else if (smp_vld_i) begin
        acc_q <= sum;
        cnt_q <= cnt_q + 11'h001;
      end
    end
  end
endmodule

// ---- design/pmla_dev.sv ----
// device end: conversion sequence, results, limit checks and alert
`timescale 1ns/1ps
module pmla_dev #(
  parameter int unsigned CYC_PER_US = pmla_pkg::CLK_MHZ
) (
  // clock and power-on reset
  input wire logic clk_i,
  input wire logic rst_i,
  // converter front end, asynchronous codes
  input wire logic [pmla_pkg::DATA_W-1:0] shunt_sample_i,
  input wire logic [pmla_pkg::DATA_W-1:0] bus_sample_i,
  input wire logic [pmla_pkg::DATA_W-1:0] temp_sample_i,
  output logic shunt_range_o,
  output logic [1:0] conv_chan_o,
  // host link
  pmla_link_if.dev link
);
  import pmla_pkg::*;

  logic [15:0] cfg_q;
  logic [15:0] adc_cfg_q;
  logic [15:0] cal_q;
  logic [15:0] shunt_over_limit_q;
  logic [15:0] bus_over_limit_q;
  logic [15:0] pow_lim_q;
  logic [15:0] shunt_q;
  logic [15:0] bus_q;
  logic [15:0] temp_q;
  logic [15:0] cur_q;
  logic [23:0] pow_q;
  logic [D_N-1:0] flags_q;
  logic [D_N-1:0] flags_set;
  logic [1:0] chan_q;
  logic [1:0] chan_nxt;
  logic [TMR_W-1:0] tmr_q;
  logic [2:0] ct_nxt;
  logic [CH_N-1:0] ch_en;
  logic [CH_N-1:0] smp_vld;
  logic [CH_N-1:0] avg_vld;
  logic [15:0] smp_in [CH_N];
  logic [15:0] smp_q [CH_N];
  logic [15:0] avg [CH_N];
  logic [2:0] upd_q;
  logic take;
  logic ack_q;
  logic alert_q;
  logic [23:0] rdata_q;
  logic [23:0] rd_mux;
  logic [15:0] sh_val;
  logic [15:0] bus_val;
  logic sh_stb;
  logic bus_stb;
  logic signed [32:0] cur_full;
  logic signed [32-CAL_SHIFT:0] cur_sh;
  logic [15:0] cur_mag;
  logic [31:0] pow_full;
  logic [31-POW_SHIFT:0] pow_sh;

  assign smp_in[CH_SHUNT] = shunt_sample_i;
  assign smp_in[CH_BUS] = bus_sample_i;
  assign smp_in[CH_TEMP] = temp_sample_i;
  assign ch_en = adc_cfg_q[F_CH_EN +: CH_N];
  assign take = link.req && !ack_q;
  assign link.ack = ack_q;
  assign link.rdata = rdata_q;
  assign link.alert = alert_q;

  // next enabled channel in shunt, bus, temperature order
  always_comb begin
    chan_nxt = chan_q;
    for (int k = CH_N - 1; k >= 1; k--) begin
      if (ch_en[(32'(chan_q) + k) % CH_N]) begin
        chan_nxt = 2'((32'(chan_q) + k) % CH_N);
      end
    end
    if (chan_nxt == CH_SHUNT) begin
      ct_nxt = adc_cfg_q[F_SHUNT_CT +: 3];
    end else if (chan_nxt == CH_BUS) begin
      ct_nxt = adc_cfg_q[F_BUS_CT +: 3];
    end else begin
      ct_nxt = adc_cfg_q[F_TEMP_CT +: 3];
    end
  end

  // continuous round-robin conversion of enabled channels
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chan_q <= CH_SHUNT;
      tmr_q <= TMR_W'(CONV_US[CT_RST] * CYC_PER_US);
    end else if (tmr_q == '0 || !ch_en[chan_q]) begin
      chan_q <= chan_nxt;
      tmr_q <= TMR_W'(CONV_US[ct_nxt] * CYC_PER_US);
    end else begin
      tmr_q <= tmr_q - 18'h00001;
    end
  end

  // per-channel sync of the front-end code and averaging
  // codes are held steady over a conversion, so a word sync is enough
  generate
    for (genvar c = 0; c < CH_N; c++) begin : g_ch
      logic [15:0] meta_q;
      always_ff @(posedge clk_i) begin
        meta_q <= smp_in[c];
        smp_q[c] <= meta_q;
      end
      assign smp_vld[c] = ch_en[c] && chan_q == 2'(c) && tmr_q == '0;
      pmla_avg u_avg (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .smp_vld_i(smp_vld[c]),
        .smp_i(smp_q[c]),
        .log2_i(AVG_LOG2[adc_cfg_q[F_AVG +: 3]]),
        .avg_vld_o(avg_vld[c]),
        .avg_o(avg[c])
      );
    end
  endgenerate

  // results in two's complement, bus clamped at zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shunt_q <= '0;
      bus_q <= '0;
      temp_q <= '0;
    end else begin
      if (avg_vld[CH_SHUNT]) begin
        shunt_q <= avg[CH_SHUNT];
      end
      if (avg_vld[CH_BUS]) begin
        bus_q <= avg[CH_BUS][15] ? 16'h0000 : avg[CH_BUS];
      end
      if (avg_vld[CH_TEMP]) begin
        temp_q <= avg[CH_TEMP];
      end
    end
  end

  // current = shunt * cal, power = |current| * bus; zero cal zeroes both
  assign cur_full = $signed(shunt_q) * $signed({1'b0, cal_q});
  assign cur_sh = cur_full[32:CAL_SHIFT];
  assign cur_mag = cur_q[15] ? 16'(-cur_q) : cur_q;
  assign pow_full = cur_mag * bus_q;
  assign pow_sh = pow_full[31:POW_SHIFT];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur_q <= '0;
      pow_q <= '0;
      upd_q <= '0;
    end else begin
      if (cal_q == '0) begin
        cur_q <= '0;
      end else if (cur_sh > 22'sh007FFF) begin
        cur_q <= 16'h7FFF;
      end else if (cur_sh < -22'sh008000) begin
        cur_q <= 16'h8000;
      end else begin
        cur_q <= cur_sh[15:0];
      end
      pow_q <= (|pow_sh[25:24]) ? 24'hFFFFFF : pow_sh[23:0];
      upd_q <= {upd_q[1:0], avg_vld[CH_SHUNT] | avg_vld[CH_BUS]};
    end
  end

  // checks on each new value: single sample, or average when selected
  assign sh_val = cfg_q[F_AVG_ALERT] ? avg[CH_SHUNT] : smp_q[CH_SHUNT];
  assign sh_stb = cfg_q[F_AVG_ALERT] ? avg_vld[CH_SHUNT] : smp_vld[CH_SHUNT];
  assign bus_val = cfg_q[F_AVG_ALERT] ? avg[CH_BUS] : smp_q[CH_BUS];
  assign bus_stb = cfg_q[F_AVG_ALERT] ? avg_vld[CH_BUS] : smp_vld[CH_BUS];
  always_comb begin
    flags_set = '0;
    flags_set[D_SHUNT_OV] = sh_stb && $signed(sh_val) > $signed(shunt_over_limit_q);
    flags_set[D_BUS_OV] = bus_stb && !bus_val[15] && bus_val > bus_over_limit_q;
    flags_set[D_POWER_OV] = upd_q[2] && pow_q[23:POW_LIM_LSB] > pow_lim_q;
    flags_set[D_CNV_RDY] = |avg_vld;
  end

  // sticky flags, cleared by reading diag; a new event beats the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_q <= '0;
    end else if (take && !link.we && link.addr == R_DIAG) begin
      flags_q <= flags_set;
    end else begin
      flags_q <= flags_q | flags_set;
    end
  end

  // alert follows the flags one cycle later, two cycles after the conversion ends for single-sample shunt and bus checks,
  // so a shunt or bus fault shows within one round of the enabled channels of crossing the limit, or two windows when averaged checks are on
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alert_q <= 1'b0;
    end else if (cfg_q[F_ALERT_RDY]) begin
      alert_q <= flags_q[D_CNV_RDY];
    end else begin
      alert_q <= |(flags_q[D_POWER_OV:D_SHUNT_OV] & cfg_q[F_MASK +: 3]);
    end
  end

  // host-writable settings, all back to defaults on power-up
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_q <= CFG_RST;
      adc_cfg_q <= ADC_CFG_RST;
      cal_q <= CAL_RST;
      shunt_over_limit_q <= SHUNT_LIM_RST;
      bus_over_limit_q <= BUS_LIM_RST;
      pow_lim_q <= POWER_LIM_RST;
    end else if (take && link.we) begin
      if (link.addr == R_CFG) begin
        cfg_q <= link.wdata;
      end else if (link.addr == R_ADC_CFG) begin
        adc_cfg_q <= link.wdata;
      end else if (link.addr == R_SHUNT_CAL) begin
        cal_q <= {1'b0, link.wdata[14:0]};
      end else if (link.addr == R_SHUNT_LIM) begin
        shunt_over_limit_q <= link.wdata;
      end else if (link.addr == R_BUS_LIM) begin
        bus_over_limit_q <= {1'b0, link.wdata[14:0]};
      end else if (link.addr == R_POWER_LIM) begin
        pow_lim_q <= link.wdata;
      end
    end
  end

  always_comb begin
    if (link.addr == R_CFG) begin
      rd_mux = {8'h00, cfg_q};
    end else if (link.addr == R_ADC_CFG) begin
      rd_mux = {8'h00, adc_cfg_q};
    end else if (link.addr == R_SHUNT_CAL) begin
      rd_mux = {8'h00, cal_q};
    end else if (link.addr == R_SHUNT) begin
      rd_mux = {8'h00, shunt_q};
    end else if (link.addr == R_BUS) begin
      rd_mux = {8'h00, bus_q};
    end else if (link.addr == R_TEMP) begin
      rd_mux = {8'h00, temp_q};
    end else if (link.addr == R_CURRENT) begin
      rd_mux = {8'h00, cur_q};
    end else if (link.addr == R_POWER) begin
      rd_mux = pow_q;
    end else if (link.addr == R_DIAG) begin
      rd_mux = {20'h00000, flags_q};
    end else if (link.addr == R_SHUNT_LIM) begin
      rd_mux = {8'h00, shunt_over_limit_q};
    end else if (link.addr == R_BUS_LIM) begin
      rd_mux = {8'h00, bus_over_limit_q};
    end else if (link.addr == R_POWER_LIM) begin
      rd_mux = {8'h00, pow_lim_q};
    end else begin
      rd_mux = '0;
    end
  end

  // one ack per request; the host drops req on seeing it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdata_q <= '0;
      shunt_range_o <= 1'b0;
      conv_chan_o <= CH_SHUNT;
    end else begin
      ack_q <= take;
      if (take) begin
        rdata_q <= link.we ? 24'h000000 : rd_mux;
      end
      shunt_range_o <= cfg_q[F_NARROW];
      conv_chan_o <= chan_q;
    end
  end
endmodule

// ---- design/pmla_host.sv ----
// host end: wishbone-controlled link master with alert interrupt
`timescale 1ns/1ps
module pmla_host (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [pmla_pkg::WB_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // interrupt
  output logic irq_o,
  // device link
  pmla_link_if.host link
);
  import pmla_pkg::*;
  logic take;
  logic wr;
  logic [15:0] wmask;
  logic [15:0] wval;
  logic req_q;
  logic we_q;
  logic [3:0] addr_q;
  logic [15:0] wdata_q;
  logic [23:0] rdata_q;
  logic reprog_q;
  logic alert_prev_q;
  logic [IRQ_N-1:0] irq_st_q;
  logic [IRQ_N-1:0] irq_en_q;
  logic [IRQ_N-1:0] irq_set;
  logic [31:0] rd_mux;

  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = take && wb_we_i;
  assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wval = wb_dat_i[15:0] & wmask;
  assign link.req = req_q;
  assign link.we = we_q;
  assign link.addr = addr_q;
  assign link.wdata = wdata_q;
  assign irq_set[I_DONE] = req_q && link.ack;
  assign irq_set[I_ALERT] = link.alert && !alert_prev_q;

  // a go while a transfer is open is ignored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_q <= 1'b0;
      we_q <= 1'b0;
      addr_q <= '0;
      wdata_q <= '0;
    end else if (req_q) begin
      if (link.ack) begin
        req_q <= 1'b0;
      end
    end else if (wr && wb_adr_i == A_CMD) begin
      if (wb_sel_i[0]) begin
        addr_q <= wb_dat_i[3:0];
        we_q <= wb_dat_i[C_WE];
      end
      if (wb_sel_i[1]) begin
        req_q <= wb_dat_i[C_GO];
      end
    end else if (wr && wb_adr_i == A_WDATA) begin
      wdata_q <= (wdata_q & ~wmask) | wval;
    end
  end

  // device defaults return on every power-up until software rewrites them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= '0;
      reprog_q <= 1'b1;
      alert_prev_q <= 1'b0;
    end else begin
      alert_prev_q <= link.alert;
      if (req_q && link.ack) begin
        rdata_q <= link.rdata;
        if (we_q && addr_q == R_SHUNT_CAL) begin
          reprog_q <= 1'b0;
        end
      end
    end
  end

  // interrupt status: set beats a same-cycle clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_st_q <= '0;
      irq_en_q <= '0;
      irq_o <= 1'b0;
    end else begin
      if (wr && wb_adr_i == A_IRQ_CLR && wb_sel_i[0]) begin
        irq_st_q <= (irq_st_q & ~wb_dat_i[IRQ_N-1:0]) | irq_set;
      end else begin
        irq_st_q <= irq_st_q | irq_set;
      end
      if (wr && wb_adr_i == A_IRQ_EN && wb_sel_i[0]) begin
        irq_en_q <= wb_dat_i[IRQ_N-1:0];
      end
      irq_o <= |(irq_st_q & irq_en_q);
    end
  end

  always_comb begin
    rd_mux = '0;
    if (wb_adr_i == A_CMD) begin
      rd_mux[3:0] = addr_q;
      rd_mux[C_WE] = we_q;
    end else if (wb_adr_i == A_WDATA) begin
      rd_mux[15:0] = wdata_q;
    end else if (wb_adr_i == A_RDATA) begin
      rd_mux[23:0] = rdata_q;
    end else if (wb_adr_i == A_STATUS) begin
      rd_mux[S_BUSY] = req_q;
      rd_mux[S_ALERT] = link.alert;
      rd_mux[S_REPROG] = reprog_q;
    end else if (wb_adr_i == A_IRQ_ST) begin
      rd_mux[IRQ_N-1:0] = irq_st_q;
    end else if (wb_adr_i == A_IRQ_EN) begin
      rd_mux[IRQ_N-1:0] = irq_en_q;
    end
  end

  // every access, mapped or not, acks one cycle after it is seen
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= take;
      if (take) begin
        wb_dat_o <= wb_we_i ? 32'h00000000 : rd_mux;
      end
    end
  end
endmodule

// ---- dv/pmla_link_chk.sv ----
// link protocol and read-data checker between host and device ends
`timescale 1ns/1ps
module pmla_link_chk (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // link signals
  input wire logic req,
  input wire logic we,
  input wire logic [pmla_pkg::ADDR_W-1:0] addr,
  input wire logic [pmla_pkg::DATA_W-1:0] wdata,
  input wire logic ack,
  input wire logic [pmla_pkg::RDATA_W-1:0] rdata,
  input wire logic alert
);
  import pmla_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_pulse; ack |=> !ack; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
  property p_ack_cause; $rose(ack) |-> $past(req); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_ack_prompt; $rose(req) |=> ack; endproperty
  a_ack_prompt: assert property (p_ack_prompt) else $error("request not answered");
  property p_req_hold; req && !ack |=> req; endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped early");
  property p_req_drop; ack |=> !req; endproperty
  a_req_drop: assert property (p_req_drop) else $error("request kept after ack");
  property p_req_stable; req && !ack |=> $stable({we, addr, wdata}); endproperty
  a_req_stable: assert property (p_req_stable) else $error("request changed");
  property p_rdata_ack; $changed(rdata) |-> ack; endproperty
  a_rdata_ack: assert property (p_rdata_ack) else $error("read data moved");
  property p_unmapped;
    ack && !$past(we) && $past(addr) > R_POWER_LIM |-> rdata == '0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_narrow;
    ack && !$past(we) && $past(addr) != R_POWER |-> rdata[23:16] == 8'h00;
  endproperty
  a_narrow: assert property (p_narrow) else $error("upper read bits set");
  property p_bus_pos; ack && !$past(we) && $past(addr) == R_BUS |-> !rdata[15]; endproperty
  a_bus_pos: assert property (p_bus_pos) else $error("negative bus result");
endmodule

// ---- dv/testbench.sv ----
// testbench joining host and device ends over the register link
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected %s exp %0h got %0h", n, e, g); end end
module testbench;
  import pmla_pkg::*;
  logic clk_i, rst_i, cyc, stb, wwe, ack, irq, range_n;
  logic [4:0] adr;
  logic [31:0] dat, wbq, q;
  logic [15:0] sh, bu, te;
  logic [1:0] chan;
  logic [23:0] r;
  int mismatches, n_tests;
  pmla_link_if lnk ();
  pmla_host i_pmla_host (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(wwe), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat), .wb_dat_o(wbq),
    .wb_ack_o(ack), .irq_o(irq), .link(lnk.host));
  // one cycle per microsecond keeps conversions short
  pmla_dev #(.CYC_PER_US(1)) i_pmla_dev (.clk_i(clk_i), .rst_i(rst_i), .shunt_sample_i(sh),
    .bus_sample_i(bu), .temp_sample_i(te), .shunt_range_o(range_n), .conv_chan_o(chan),
    .link(lnk.dev));
  pmla_link_chk i_pmla_link_chk (.clk_i(clk_i), .rst_i(rst_i), .req(lnk.req), .we(lnk.we),
    .addr(lnk.addr), .wdata(lnk.wdata), .ack(lnk.ack), .rdata(lnk.rdata), .alert(lnk.alert));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    wwe <= w;
    adr <= a;
    dat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    if (ack !== 1'b1) mismatches++;
    q = wbq;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // device access: data, command with go, poll busy, fetch read data
  task automatic dv(input logic w, input logic [3:0] i, input logic [15:0] d);
    int k;
    wb(1'b1, A_WDATA, {16'h0000, d});
    wb(1'b1, A_CMD, {23'h000000, 1'b1, 3'h0, w, i});
    k = 0;
    do begin
      wb(1'b0, A_STATUS, 32'h0);
      k++;
    end while (q[S_BUSY] !== 1'b0 && k < 50);
    if (q[S_BUSY] !== 1'b0) mismatches++;
    wb(1'b0, A_RDATA, 32'h0);
    r = q[23:0];
  endtask
  task automatic t_reset;
    logic [3:0] ri [6];
    logic [15:0] rv [6];
    ri = '{R_CFG, R_ADC_CFG, R_SHUNT_CAL, R_SHUNT_LIM, R_BUS_LIM, R_POWER_LIM};
    rv = '{CFG_RST, ADC_CFG_RST, CAL_RST, SHUNT_LIM_RST, BUS_LIM_RST, POWER_LIM_RST};
    `CHK("range", 1'b0, range_n)
    for (int j = 0; j < 6; j++) begin
      dv(1'b0, ri[j], 16'h0000);
      `CHK("reset value", rv[j], r[15:0])
    end
    wb(1'b0, A_STATUS, 32'h0);
    `CHK("reprog", 1'b1, q[S_REPROG])
  endtask
  task automatic t_range;
    dv(1'b1, R_CFG, 16'h0039);
    idle(2);
    `CHK("narrow", 1'b1, range_n)
    dv(1'b1, R_CFG, 16'h0038);
    idle(2);
    `CHK("wide", 1'b0, range_n)
  endtask
  task automatic t_cal;
    logic [2:0] seen;
    seen = 3'h0;
    sh <= 16'h03E8;
    bu <= 16'h00C8;
    dv(1'b1, R_ADC_CFG, 16'h7000);
    idle(1500);
    repeat (400) @(posedge clk_i) seen[chan] = 1'b1;
    `CHK("channels", 3'h7, seen)
    dv(1'b0, R_CURRENT, 16'h0000);
    `CHK("current uncal", 24'h000000, r)
    dv(1'b0, R_POWER, 16'h0000);
    `CHK("power uncal", 24'h000000, r)
    dv(1'b1, R_SHUNT_CAL, 16'h0800);
    wb(1'b0, A_STATUS, 32'h0);
    `CHK("reprog", 1'b0, q[S_REPROG])
    idle(400);
    dv(1'b0, R_CURRENT, 16'h0000);
    `CHK("current", 24'h0003E8, r)
    dv(1'b0, R_POWER, 16'h0000);
    `CHK("power", 24'h000C35, r)
  endtask
  task automatic t_limits;
    dv(1'b1, R_SHUNT_LIM, 16'h03E8);
    dv(1'b1, R_BUS_LIM, 16'h00C8);
    dv(1'b1, R_POWER_LIM, 16'h000C);
    wb(1'b1, A_IRQ_EN, 32'h2);
    idle(400);
    dv(1'b0, R_DIAG, 16'h0000);
    idle(400);
    dv(1'b0, R_DIAG, 16'h0000);
    `CHK("at limit", 3'h0, r[2:0])
    `CHK("ready flag", 1'b1, r[D_CNV_RDY])
    for (int j = 0; j < 3; j++) begin
      if (j == 0) sh <= 16'h03E9;
      if (j == 1) bu <= 16'h00C9;
      if (j == 2) dv(1'b1, R_POWER_LIM, 16'h000B);
      idle(400);
      wb(1'b0, A_STATUS, 32'h0);
      `CHK("alert", 1'b1, q[S_ALERT])
      `CHK("irq", 1'b1, irq)
      wb(1'b1, A_IRQ_CLR, 32'h2);
      idle(3);
      `CHK("irq cleared", 1'b0, irq)
      dv(1'b0, R_DIAG, 16'h0000);
      `CHK("fault", 3'h1 << j, r[2:0])
      sh <= 16'h03E8;
      bu <= 16'h00C8;
      dv(1'b1, R_POWER_LIM, 16'h000C);
      idle(400);
      dv(1'b0, R_DIAG, 16'h0000);
    end
    // shunt fault with its mask bit off must stay silent
    sh <= 16'h03E9;
    dv(1'b1, R_CFG, 16'h0030);
    idle(400);
    dv(1'b0, R_DIAG, 16'h0000);
    idle(400);
    wb(1'b0, A_STATUS, 32'h0);
    `CHK("masked alert", 1'b0, q[S_ALERT])
    sh <= 16'h03E8;
    dv(1'b1, R_CFG, 16'h0038);
  endtask
  task automatic t_ready;
    // fault mask off, so only the ready source can raise alert
    dv(1'b1, R_CFG, 16'h0004);
    idle(400);
    wb(1'b0, A_STATUS, 32'h0);
    `CHK("ready alert", 1'b1, q[S_ALERT])
    dv(1'b1, R_CFG, 16'h0038);
  endtask
  // four-sample averages: a one-code step needs a full window to trip
  task automatic t_avg;
    dv(1'b1, R_CFG, 16'h003A);
    dv(1'b1, R_ADC_CFG, 16'h7001);
    idle(700);
    dv(1'b0, R_DIAG, 16'h0000);
    sh <= 16'h03E9;
    idle(200);
    wb(1'b0, A_STATUS, 32'h0);
    `CHK("avg alert early", 1'b0, q[S_ALERT])
    idle(1200);
    wb(1'b0, A_STATUS, 32'h0);
    `CHK("avg alert", 1'b1, q[S_ALERT])
    sh <= 16'h03E8;
    dv(1'b1, R_ADC_CFG, 16'h7000);
    dv(1'b1, R_CFG, 16'h0038);
    idle(400);
    dv(1'b0, R_DIAG, 16'h0000);
  endtask
  task automatic t_sign;
    sh <= 16'hB410;
    bu <= 16'h8000;
    te <= 16'hFF38;
    idle(400);
    dv(1'b0, R_SHUNT, 16'h0000);
    `CHK("shunt", 24'h00B410, r)
    dv(1'b0, R_CURRENT, 16'h0000);
    `CHK("neg current", 24'h00B410, r)
    dv(1'b0, R_BUS, 16'h0000);
    `CHK("bus clamp", 24'h000000, r)
    dv(1'b0, R_TEMP, 16'h0000);
    `CHK("temp", 24'h00FF38, r)
    dv(1'b0, 4'hF, 16'h0000);
    `CHK("dev unmapped", 24'h000000, r)
    wb(1'b0, 5'h1C, 32'h0);
    `CHK("wb unmapped", 32'h00000000, q)
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    wwe = 1'b0;
    adr = 5'h00;
    dat = 32'h0;
    sh = 16'h0000;
    bu = 16'h0000;
    te = 16'h0000;
    mismatches = 0;
    n_tests = 0;
    rst_i = 1'b1;
    idle(16);
    rst_i <= 1'b0;
    t_reset;
    t_range;
    t_cal;
    t_limits;
    t_ready;
    t_avg;
    t_sign;
    finish_test;
  end
  // tests need a little over ten thousand cycles
  initial begin
    idle(60000);
    mismatches++;
    finish_test;
  end
endmodule
